// [hdl/ifr_target.sv]
// Two-wire read-only target returning checksum and flow count bytes.
`timescale 1ns/1ps
// Function
// - Acknowledge only address 0x50; ignore every other target address.
// - Work at both 100 kHz and 400 kHz bus bit rates.
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop condition.
// - Each byte is eight data bits plus one response bit.
// - Drive data low during the response bit to acknowledge, then release.
// - Sample on rising clock; keep data stable while clock is high.
// - After an acknowledge, continue with another byte or stop.
// - Measure continuously so any read returns a fresh result.
// - Send every byte most significant bit first.
// - Return checksum first, then the two flow data bytes.
// - Flow is 12-bit unsigned; high byte upper four bits are zero.
// - Checksum is the negated modulo-256 sum of data bytes only.
// - Five-byte read: checksum plus four data bytes, all covered.
module ifr_target (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic meas_valid_i,
  input wire logic [11:0] meas_count_i,
  output logic meas_ready_o,
  output logic busy_o
);
  ifr_pkg::ifr_state_t state_reg, state_next;
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_d_reg, sda_d_reg;
  logic scl_s, sda_s;
  logic scl_rise, scl_fall, start_evt, stop_evt;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] idx_reg, idx_next;
  logic acked_reg, acked_next;
  logic oe_reg, oe_next;
  logic busy_reg, busy_next;
  logic [11:0] latest_reg, latest_next;
  ifr_pkg::ifr_frame_t frame_reg, frame_next;
  logic fifo_valid, fifo_pop;
  logic [11:0] fifo_data;
  logic [7:0] load_byte;

  function automatic ifr_pkg::ifr_frame_t make_frame(input logic [11:0] c);
    ifr_pkg::ifr_frame_t f;
    f.hi = {4'h0, c[11:8]};
    f.lo = c[7:0];
    // The two trailing pad bytes are zero, so one checksum covers both
    // the three-byte and the five-byte read.
    f.csum = 8'(8'h00 - 8'(f.hi + f.lo));
    return f;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [2:0] i,
                                           input ifr_pkg::ifr_frame_t f);
    logic [7:0] b;
    b = ifr_pkg::PAD_BYTE;
    if (i == ifr_pkg::IDX_CSUM) begin
      b = f.csum;
    end else if (i == ifr_pkg::IDX_HI) begin
      b = f.hi;
    end else if (i == ifr_pkg::IDX_LO) begin
      b = f.lo;
    end
    return b;
  endfunction

  // Measurements queue here; the queue stalls while a read is in flight.
  ifr_fifo #(
    .WIDTH(ifr_pkg::COUNT_W),
    .DEPTH(ifr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(meas_valid_i),
    .in_data_i(meas_count_i),
    .in_ready_o(meas_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  // Twelve samples per half bit at the fast rate leave ample sampling margin.
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_evt = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_evt = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign load_byte = pick_byte(idx_reg, frame_reg);
  assign fifo_pop = fifo_valid &&
                    (state_reg == ifr_pkg::ST_IDLE ||
                     state_reg == ifr_pkg::ST_SKIP);
  assign sda_oe_o = oe_reg;
  assign busy_o = busy_reg;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    acked_next = acked_reg;
    oe_next = oe_reg;
    frame_next = frame_reg;
    latest_next = fifo_pop ? fifo_data : latest_reg;
    unique case (state_reg)
      ifr_pkg::ST_IDLE, ifr_pkg::ST_SKIP: begin
      end
      ifr_pkg::ST_ADDR: begin
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_s};
          cnt_next = 4'(cnt_reg + 1'b1);
        end else if (scl_fall && cnt_reg == ifr_pkg::BITS_PER_BYTE) begin
          if (shift_reg == {ifr_pkg::TGT_ADDR, ifr_pkg::RD_DIR}) begin
            state_next = ifr_pkg::ST_AACK;
            oe_next = 1'b1;
            frame_next = make_frame(latest_reg);
            idx_next = ifr_pkg::IDX_CSUM;
          end else begin
            state_next = ifr_pkg::ST_SKIP;
          end
        end
      end
      ifr_pkg::ST_AACK, ifr_pkg::ST_MACK: begin
        if (scl_rise && state_reg == ifr_pkg::ST_MACK) begin
          acked_next = !sda_s;
        end else if (scl_fall) begin
          if (state_reg == ifr_pkg::ST_AACK || acked_reg) begin
            state_next = ifr_pkg::ST_TX;
            shift_next = load_byte;
            oe_next = !load_byte[7];
            cnt_next = ifr_pkg::BIT_CNT_RST;
            if (idx_reg != ifr_pkg::IDX_MAX) begin
              idx_next = 3'(idx_reg + 1'b1);
            end
          end else begin
            state_next = ifr_pkg::ST_SKIP;
            oe_next = 1'b0;
          end
        end
      end
      ifr_pkg::ST_TX: begin
        if (scl_rise) begin
          cnt_next = 4'(cnt_reg + 1'b1);
        end else if (scl_fall) begin
          if (cnt_reg == ifr_pkg::BITS_PER_BYTE) begin
            state_next = ifr_pkg::ST_MACK;
            oe_next = 1'b0;
            acked_next = 1'b0;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next = !shift_reg[6];
          end
        end
      end
      default: begin
        state_next = ifr_pkg::ST_IDLE;
        oe_next = 1'b0;
      end
    endcase
    // Bus conditions override whatever byte was in progress.
    if (stop_evt) begin
      state_next = ifr_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else if (start_evt) begin
      state_next = ifr_pkg::ST_ADDR;
      cnt_next = ifr_pkg::BIT_CNT_RST;
      oe_next = 1'b0;
    end
    busy_next = (state_next != ifr_pkg::ST_IDLE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= ifr_pkg::ST_IDLE;
      shift_reg <= ifr_pkg::SHIFT_RST;
      cnt_reg <= ifr_pkg::BIT_CNT_RST;
      idx_reg <= ifr_pkg::IDX_CSUM;
      acked_reg <= 1'b0;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      sda_o <= 1'b0;
      latest_reg <= ifr_pkg::COUNT_RST;
      frame_reg <= make_frame(ifr_pkg::COUNT_RST);
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      acked_reg <= acked_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      sda_o <= 1'b0;
      latest_reg <= latest_next;
      frame_reg <= frame_next;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_addr_match: assert property (
    $rose(state_reg == ifr_pkg::ST_AACK) |->
      shift_reg == {ifr_pkg::TGT_ADDR, ifr_pkg::RD_DIR} && sda_oe_o)
    else $error("Acknowledged a foreign address.");

  a_addr_skip: assert property (
    state_reg == ifr_pkg::ST_ADDR && scl_fall &&
    cnt_reg == ifr_pkg::BITS_PER_BYTE &&
    shift_reg != {ifr_pkg::TGT_ADDR, ifr_pkg::RD_DIR} && !stop_evt &&
    !start_evt |=> state_reg == ifr_pkg::ST_SKIP && !sda_oe_o)
    else $error("Foreign address not ignored.");

  a_start_seen: assert property (
    start_evt && !stop_evt |=> state_reg == ifr_pkg::ST_ADDR &&
      cnt_reg == 4'h0 && !sda_oe_o)
    else $error("Start condition missed.");

  a_stop_release: assert property (
    stop_evt |=> state_reg == ifr_pkg::ST_IDLE && !sda_oe_o ##1 !busy_o)
    else $error("Stop did not release the bus.");

  a_ack_release: assert property (
    state_reg == ifr_pkg::ST_AACK && scl_fall && !start_evt && !stop_evt
      |=> state_reg == ifr_pkg::ST_TX && idx_reg == ifr_pkg::IDX_HI)
    else $error("Acknowledge not followed by checksum byte.");

  a_byte_len: assert property (
    state_reg == ifr_pkg::ST_TX |-> cnt_reg <= ifr_pkg::BITS_PER_BYTE)
    else $error("Byte longer than eight bits.");

  a_stable_high: assert property (
    scl_s && scl_d_reg |=> $stable(sda_oe_o) || $past(start_evt) ||
      $past(stop_evt))
    else $error("Data changed while clock high.");

  a_msb_first: assert property (
    state_reg == ifr_pkg::ST_TX |-> sda_oe_o == !shift_reg[7])
    else $error("Driven bit is not the shift register head.");

  a_checksum: assert property (
    8'(frame_reg.csum + frame_reg.hi + frame_reg.lo) == 8'h00 &&
      frame_reg.hi[7:4] == 4'h0)
    else $error("Checksum does not cancel data bytes.");

  a_fresh_take: assert property (
    fifo_pop |=> latest_reg == $past(fifo_data))
    else $error("Queued measurement not taken.");

  a_ack_drive: assert property (
    state_reg == ifr_pkg::ST_AACK |-> sda_oe_o)
    else $error("Address acknowledge not driven.");

  a_ctrl_ack_free: assert property (
    state_reg == ifr_pkg::ST_MACK |-> !sda_oe_o)
    else $error("Line held during controller response.");

  // Rebuilt from the count itself, so a broken frame helper cannot hide.
  a_frame_snap: assert property (
    $rose(state_reg == ifr_pkg::ST_AACK) |->
      frame_reg.hi == {4'h0, $past(latest_reg[11:8])} &&
      frame_reg.lo == $past(latest_reg[7:0]) &&
      frame_reg.csum == 8'(8'h00 - {4'h0, $past(latest_reg[11:8])} -
        $past(latest_reg[7:0])))
    else $error("Frame does not match the latest count.");

  a_byte_order: assert property (
    $rose(state_reg == ifr_pkg::ST_TX) && idx_reg == ifr_pkg::IDX_HI |->
      shift_reg == frame_reg.csum)
    else $error("First byte is not the checksum.");

  a_data_order: assert property (
    $rose(state_reg == ifr_pkg::ST_TX) && idx_reg != ifr_pkg::IDX_HI |->
      shift_reg == (idx_reg == ifr_pkg::IDX_LO ? frame_reg.hi :
        idx_reg == 3'(ifr_pkg::IDX_LO + 3'h1) ? frame_reg.lo :
        ifr_pkg::PAD_BYTE))
    else $error("Data byte sent out of order.");

  a_nack_skip: assert property (
    state_reg == ifr_pkg::ST_MACK && scl_fall && !acked_reg && !start_evt &&
      !stop_evt |=> state_reg == ifr_pkg::ST_SKIP && !sda_oe_o)
    else $error("Refused byte did not end the transfer.");

  c_read_ack: cover property (
    state_reg == ifr_pkg::ST_AACK ##[1:300] state_reg == ifr_pkg::ST_TX);
  c_foreign: cover property (state_reg == ifr_pkg::ST_SKIP);
  c_five_bytes: cover property (
    idx_reg == 3'h5 && state_reg == ifr_pkg::ST_MACK);
  c_fifo_full: cover property (!meas_ready_o && meas_valid_i);
  c_nack_end: cover property (
    state_reg == ifr_pkg::ST_MACK ##[1:300] state_reg == ifr_pkg::ST_SKIP);
endmodule

// [hdl/ifr_pkg.sv]
// Shared constants, types and state encoding for the flow readout target.
package ifr_pkg;

  localparam logic [6:0] TGT_ADDR = 7'h50;
  localparam logic RD_DIR = 1'b1;
  localparam int CLK_HZ = 10_000_000;
  localparam int FAST_BIT_HZ = 400_000;
  localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_BIT_HZ);
  localparam int COUNT_W = 12;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [2:0] IDX_CSUM = 3'h0;
  localparam logic [2:0] IDX_HI = 3'h1;
  localparam logic [2:0] IDX_LO = 3'h2;
  localparam logic [2:0] IDX_MAX = 3'h7;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [11:0] COUNT_RST = 12'h000;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] csum;
    logic [7:0] hi;
    logic [7:0] lo;
  } ifr_frame_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_TX,
    ST_MACK,
    ST_SKIP
  } ifr_state_t;

endpackage

// [hdl/ifr_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ifr_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic push, pop;

  assign push = in_valid_i && ready_reg;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = ready_reg;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];

  always_comb begin
    wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
    // Registered ready keeps the source-side path free of the pop logic.
    ready_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end
endmodule

// [bench/ifr_ctrl_model.sv]
// Behavioural bus controller that reads the flow target.
`timescale 1ns/1ps
module ifr_ctrl_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o,
  output logic rx_stb_o,
  output logic [7:0] rx_byte_o
);
  // Half of the bench's 800 ns bus clock period unless a test changes it.
  int half_ns = 400;

  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rx_stb_o = 1'b0;
    rx_byte_o = 8'h00;
  end

  // Data moves only mid-low so no false start or stop can appear.
  task automatic put_bit(input logic b, output logic s);
    #(half_ns / 2) sda_oe_o = !b;
    #(half_ns / 2) scl_o = 1'b1;
    s = sda_i;
    #(half_ns) scl_o = 1'b0;
  endtask

  task automatic start();
    sda_oe_o = 1'b0;
    scl_o = 1'b1;
    #(half_ns) sda_oe_o = 1'b1;
    #(half_ns) scl_o = 1'b0;
  endtask

  task automatic stop();
    #(half_ns / 2) sda_oe_o = 1'b1;
    #(half_ns / 2) scl_o = 1'b1;
    #(half_ns) sda_oe_o = 1'b0;
    #(half_ns);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic resp,
                      input logic pub_ack);
    logic [7:0] rx;
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(resp, a);
    rx_byte_o = pub_ack ? {7'h00, a} : rx;
    rx_stb_o = 1'b1;
    #1 rx_stb_o = 1'b0;
  endtask

  // The last wanted byte is refused so the target lets go of the line.
  task automatic read(input logic [6:0] addr, input logic dir,
                      input int n);
    start();
    xfer({addr, dir}, 1'b1, 1'b1);
    for (int k = 0; k < n; k++) xfer(8'hff, k == n - 1, 1'b0);
    stop();
  endtask
endmodule

// [bench/ifr_target_tb.sv]
// Self-checking bench for the flow readout target.
`timescale 1ns/1ps
module ifr_target_tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic meas_valid_i = 1'b0;
  logic [11:0] meas_count_i = 12'h000;
  logic sda_o, sda_oe_o, meas_ready_o, busy_o;
  logic scl, ctrl_oe, rx_stb, sda_wire, rdy_s;
  logic [7:0] rx_byte;
  logic [7:0] exp_q[$];
  logic [11:0] latest = 12'h000;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  integer seed = 32'h452e;

  always #50 ref_clk_i = ~ref_clk_i;
  // Either party pulling low wins over the pull-up.
  assign sda_wire = (sda_oe_o ? sda_o : 1'b1) & !ctrl_oe;
  // Ready as the target sees it at the next rising edge.
  always @(negedge ref_clk_i) rdy_s = meas_ready_o;

  ifr_target dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .meas_valid_i(meas_valid_i), .meas_count_i(meas_count_i),
    .meas_ready_o(meas_ready_o), .busy_o(busy_o));
  ifr_ctrl_model ctrl (.sda_i(sda_wire), .scl_o(scl), .sda_oe_o(ctrl_oe),
    .rx_stb_o(rx_stb), .rx_byte_o(rx_byte));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic compare(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) begin
      compare("unexpected byte", {4'h0, rx_byte}, 12'hfff);
    end else begin
      compare("bus byte", {4'h0, rx_byte}, {4'h0, exp_q.pop_front()});
    end
  end

  task automatic expect_read(input logic [11:0] c, input int n);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = {4'h0, c[11:8]};
    lo = c[7:0];
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00 - hi - lo);
    exp_q.push_back(hi);
    exp_q.push_back(lo);
    for (int i = 3; i < n; i++) exp_q.push_back(8'h00);
  endtask

  // Holds valid up for n edges; a word counts only when ready was high.
  task automatic burst(input int n, output int taken);
    taken = 0;
    meas_valid_i = 1'b1;
    meas_count_i = 12'($random(seed));
    repeat (n) begin
      @(posedge ref_clk_i);
      if (rdy_s === 1'b1) begin
        taken++;
        latest = meas_count_i;
      end
      #1;
      meas_count_i = 12'($random(seed));
    end
    meas_valid_i = 1'b0;
  endtask

  initial begin
    int taken;
    logic [6:0] addr;
    repeat (4) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    compare("ready after reset", {11'h0, meas_ready_o}, 12'h001);
    compare("data level", {11'h0, sda_o}, 12'h000);
    compare("oe after reset", {11'h0, sda_oe_o}, 12'h000);
    expect_read(12'h000, 5);
    ctrl.read(ifr_pkg::TGT_ADDR, ifr_pkg::RD_DIR, 5);
    for (int r = 0; r < 2; r++) begin
      ctrl.half_ns = (r == 0) ? 5000 : 1250;
      @(posedge ref_clk_i);
      #1;
      burst(3, taken);
      repeat (12) @(posedge ref_clk_i);
      expect_read(latest, 3);
      ctrl.read(ifr_pkg::TGT_ADDR, ifr_pkg::RD_DIR, 3);
    end
    ctrl.half_ns = 400;
    // Foreign targets and write direction must both be refused.
    for (int k = 0; k < 3; k++) begin
      addr = 7'($random(seed));
      if (addr == ifr_pkg::TGT_ADDR) addr = addr ^ 7'h01;
      exp_q.push_back(8'h01);
      ctrl.read(addr, 1'b1, 0);
    end
    exp_q.push_back(8'h01);
    ctrl.read(ifr_pkg::TGT_ADDR, 1'b0, 0);
    // The frame is frozen at the address ack while the FIFO backs up.
    expect_read(latest, 5);
    fork
      ctrl.read(ifr_pkg::TGT_ADDR, ifr_pkg::RD_DIR, 5);
      begin
        @(posedge rx_stb);
        @(posedge ref_clk_i);
        #1;
        compare("busy in read", {11'h0, busy_o}, 12'h001);
        burst(10, taken);
        compare("words taken", 12'(taken), 12'(ifr_pkg::FIFO_DEPTH));
        compare("ready when full", {11'h0, rdy_s}, 12'h000);
      end
    join
    repeat (12) @(posedge ref_clk_i);
    #1;
    compare("busy after stop", {11'h0, busy_o}, 12'h000);
    compare("oe after stop", {11'h0, sda_oe_o}, 12'h000);
    compare("ready drained", {11'h0, meas_ready_o}, 12'h001);
    expect_read(latest, 3);
    ctrl.read(ifr_pkg::TGT_ADDR, ifr_pkg::RD_DIR, 3);
    compare("left over notes", 12'(exp_q.size()), 12'h000);
    report_and_stop();
  end
endmodule
